// ==== icm_master.sv ====
// Two-wire master: start, restart, stop, acknowledge, byte send, arbitration
`default_nettype none
// What this block does
// R1: Ack request pulls SCL low, shows ack value
// R2: Software sets ack value before requesting ack
// R3: Ack: count, release SCL, wait high, count, low
// R4: Buffer write during ack sets write collision
// R5: Stop: SDA low, count, release SCL, release SDA
// R6: Stop seen sets flag; later clears request, sets event
// R7: Buffer write during stop sets write collision
// R8: In sleep, completed transfer wakes when enabled
// R9: Reset disables port, aborts any transfer
// R10: Start/stop seen bits cleared by reset, disable
// R11: Take bus only when free; stop interrupts; a start here checks only the SDA and SCL levels, not bus_free
// R12: Released SDA read low sets bus collision
// R13: Send collision: halt, clear full, release lines
// R14: Condition collision: abort, release, clear requests
// R15: After collision, bus stop sets serial event
// R16: Buffer write after collision starts at bit one
// R17: Low line at start begin: collision, idle
// R18: Start: SDA high, count; SCL low is collision
// R19: Early SDA low restarts count; then SCL low
// R20: Restart: count, release SCL, low SDA collides
// R21: Restart hold: SDA fall fine, SCL fall collides
// R22: Restart timeout: SDA low, count, SCL low
// R23: Lines are open drain only
module icm_master #(
  parameter int RELOAD_W = icm_pkg::RELOAD_W,
  parameter int DATA_W = icm_pkg::DATA_W
) (
  // Processor clock domain
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Link clock domain
  input wire logic link_clk,
  // Control inputs
  input wire logic port_enable,
  input wire logic irq_enable,
  input wire logic sleep_mode,
  input wire logic ack_value,
  input wire logic [RELOAD_W-1:0] baud_reload_value,
  // Request write strobes
  input wire logic start_req_wr,
  input wire logic restart_req_wr,
  input wire logic stop_req_wr,
  input wire logic ack_req_wr,
  input wire logic buf_wr,
  input wire logic [DATA_W-1:0] buf_wdata,
  // Flag clear strobes
  input wire logic write_collision_flag_clr,
  input wire logic event_clr,
  input wire logic bcol_clr,
  // Request and status outputs
  output logic start_request,
  output logic restart_request,
  output logic stop_request,
  output logic ack_sequence_request,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  output logic serial_event_flag,
  output logic bus_collision_flag,
  output logic start_detected,
  output logic stop_detected,
  output logic bus_free,
  output logic wake,
  // Bus pins
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe
);

  // Refuse widths the counter and shifter cannot serve
  if (RELOAD_W < 1 || RELOAD_W > 16 || DATA_W != icm_pkg::DATA_W) begin : g_chk
    $error("icm_master: unsupported parameter value");
  end

  // Counter has reached zero
  function automatic logic cnt_zero(input logic [RELOAD_W-1:0] c);
    cnt_zero = (c == '0);
  endfunction : cnt_zero

  // ---------------- Processor domain ----------------
  logic busy_r; // A sequence is in flight on the link
  icm_pkg::icm_cmd_type cmd_r; // Sequence in flight
  logic cmd_tgl_r; // Flips once per issued sequence
  logic ackv_r; // Held ack level for the link
  logic [RELOAD_W-1:0] baud_r; // Held reload for the link
  logic [DATA_W-1:0] txd_r; // Held byte for the link
  // Synchronisers of link results
  logic done_s1, done_s2, done_s3;
  logic stp_s1, stp_s2, stp_s3;
  logic sdet_s1, sdet_s2, pdet_s1, pdet_s2;
  logic bcl_l_r; // Collision result, stable before its done toggle
  logic done_tgl_r, stp_tgl_r; // Link event toggles
  logic start_det_r, stop_det_r; // Link-side bus state bits
  logic done_ev, stp_ev, any_req;

  assign done_ev = done_s2 ^ done_s3;
  assign stp_ev = stp_s2 ^ stp_s3;
  assign any_req = start_req_wr | restart_req_wr | stop_req_wr | ack_req_wr;

  // Event toggles and status levels arriving from the link
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {done_s1, done_s2, done_s3} <= 3'h0;
      {stp_s1, stp_s2, stp_s3} <= 3'h0;
      {sdet_s1, sdet_s2, pdet_s1, pdet_s2} <= 4'h0;
    end else if (ce) begin
      done_s1 <= done_tgl_r;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      stp_s1 <= stp_tgl_r;
      stp_s2 <= stp_s1;
      stp_s3 <= stp_s2;
      sdet_s1 <= start_det_r;
      sdet_s2 <= sdet_s1;
      pdet_s1 <= stop_det_r;
      pdet_s2 <= pdet_s1;
    end
  end

  // Issue of sequences; one at a time, no queueing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0; // [R9]
      cmd_r <= icm_pkg::CMD_NONE;
      cmd_tgl_r <= 1'b0;
      ackv_r <= 1'b0;
      baud_r <= icm_pkg::CNT_RESET;
      txd_r <= icm_pkg::DATA_RESET;
      {start_request, restart_request} <= 2'h0;
      {stop_request, ack_sequence_request} <= 2'h0;
      buffer_full_flag <= 1'b0;
    end else if (ce) begin
      if (!port_enable) begin
        // Disabled port abandons whatever was running
        busy_r <= 1'b0; // [R9]
        {start_request, restart_request} <= 2'h0;
        {stop_request, ack_sequence_request} <= 2'h0;
        buffer_full_flag <= 1'b0;
      end else if (busy_r) begin
        if (done_ev) begin
          // Completion or collision clears the request bits
          busy_r <= 1'b0;
          {start_request, restart_request} <= 2'h0; // [R14]
          {stop_request, ack_sequence_request} <= 2'h0; // [R6] [R3]
          buffer_full_flag <= 1'b0; // [R13]
        end
      end else if (any_req) begin
        busy_r <= 1'b1;
        cmd_tgl_r <= ~cmd_tgl_r;
        ackv_r <= ack_value; // [R2]
        baud_r <= baud_reload_value;
        if (start_req_wr) begin
          cmd_r <= icm_pkg::CMD_START;
          start_request <= 1'b1;
        end else if (restart_req_wr) begin
          cmd_r <= icm_pkg::CMD_RESTART;
          restart_request <= 1'b1;
        end else if (stop_req_wr) begin
          cmd_r <= icm_pkg::CMD_STOP;
          stop_request <= 1'b1;
        end else begin
          cmd_r <= icm_pkg::CMD_ACK;
          ack_sequence_request <= 1'b1; // [R1]
        end
      end else if (buf_wr) begin
        // Byte send always restarts from the top bit
        busy_r <= 1'b1;
        cmd_tgl_r <= ~cmd_tgl_r;
        cmd_r <= icm_pkg::CMD_TX; // [R16]
        baud_r <= baud_reload_value;
        txd_r <= buf_wdata;
        buffer_full_flag <= 1'b1;
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_collision_flag <= 1'b0;
      serial_event_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else if (ce) begin
      // Writes refused while any sequence runs
      write_collision_flag <= (write_collision_flag & ~write_collision_flag_clr)
        | (port_enable & busy_r & buf_wr); // [R4] [R7]
      bus_collision_flag <= (bus_collision_flag & ~bcol_clr)
        | (port_enable & busy_r & done_ev & bcl_l_r); // [R12]
      // Own non-ack sequence end without collision, or a stop seen while not driving the bus
      serial_event_flag <= (serial_event_flag & ~event_clr)
        | (port_enable & busy_r & done_ev & ~bcl_l_r
           & (cmd_r != icm_pkg::CMD_ACK)) // [R6]
        | (port_enable & ~busy_r & stp_ev); // [R15] [R11]
    end
  end

  // Bus state and wake outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_detected <= 1'b0; // [R10]
      stop_detected <= 1'b0; // [R10]
      bus_free <= 1'b0;
      wake <= 1'b0;
    end else if (ce) begin
      start_detected <= port_enable & sdet_s2; // [R10]
      stop_detected <= port_enable & pdet_s2; // [R10]
      bus_free <= port_enable & (pdet_s2 | ~sdet_s2); // [R11]
      wake <= sleep_mode & irq_enable & serial_event_flag; // [R8]
    end
  end

  // ---------------- Link domain ----------------
  logic sda_s1, sda_s2, scl_s1, scl_s2; // Pin synchronisers
  logic en_s1, en_s2, ce_s1, ce_s2, cmd_s1, cmd_s2;
  logic sda_d, scl_d; // Previous synchronised levels
  logic cmd_seen_r;
  icm_pkg::icm_state_type state_r;
  logic [RELOAD_W-1:0] cnt_r;
  logic [3:0] bit_r;
  logic [DATA_W-1:0] sh_r;
  logic bus_start, bus_stop;

  // Synchronisers of pins and processor-side levels
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      {sda_s1, sda_s2, scl_s1, scl_s2} <= 4'hf;
      {en_s1, en_s2, ce_s1, ce_s2} <= 4'h0;
      {cmd_s1, cmd_s2} <= 2'h0;
    end else begin
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      en_s1 <= port_enable;
      en_s2 <= en_s1;
      ce_s1 <= ce;
      ce_s2 <= ce_s1;
      cmd_s1 <= cmd_tgl_r;
      cmd_s2 <= cmd_s1;
    end
  end

  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // Bus monitor: start and stop conditions from any master
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      {sda_d, scl_d} <= 2'h3;
      start_det_r <= 1'b0;
      stop_det_r <= 1'b0;
      stp_tgl_r <= 1'b0;
    end else if (ce_s2) begin
      sda_d <= sda_s2;
      scl_d <= scl_s2;
      if (!en_s2) begin
        start_det_r <= 1'b0; // [R10]
        stop_det_r <= 1'b0; // [R10]
      end else if (bus_start) begin
        start_det_r <= 1'b1;
        stop_det_r <= 1'b0;
      end else if (bus_stop) begin
        start_det_r <= 1'b0;
        stop_det_r <= 1'b1; // [R6]
        stp_tgl_r <= ~stp_tgl_r; // [R15]
      end
    end
  end

  // Pin output levels never change; only the enables move
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      sda_o <= icm_pkg::LINE_PULL; // [R23]
      scl_o <= icm_pkg::LINE_PULL; // [R23]
    end else begin
      sda_o <= icm_pkg::LINE_PULL;
      scl_o <= icm_pkg::LINE_PULL;
    end
  end

  // Condition sequencer; held processor words are stable while busy
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= icm_pkg::S_IDLE;
      cnt_r <= icm_pkg::CNT_RESET;
      bit_r <= icm_pkg::FIRST_BIT_IDX;
      sh_r <= icm_pkg::DATA_RESET;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      cmd_seen_r <= 1'b0;
      done_tgl_r <= 1'b0;
      bcl_l_r <= 1'b0;
    end else if (ce_s2) begin
      if (!en_s2) begin
        // Disabled: abort and let go of both lines
        state_r <= icm_pkg::S_IDLE; // [R9]
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        cmd_seen_r <= cmd_s2;
      end else begin
        case (state_r)
          icm_pkg::S_IDLE: begin
            if (cmd_s2 != cmd_seen_r) begin
              cmd_seen_r <= cmd_s2;
              cnt_r <= baud_r;
              bcl_l_r <= 1'b0;
              case (cmd_r)
                icm_pkg::CMD_START: state_r <= icm_pkg::S_ST_CHK;
                icm_pkg::CMD_RESTART: begin
                  scl_oe <= 1'b1;
                  sda_oe <= 1'b0;
                  state_r <= icm_pkg::S_RS_REL;
                end
                icm_pkg::CMD_STOP: begin
                  sda_oe <= 1'b1; // [R5]
                  state_r <= icm_pkg::S_SP_SDAL;
                end
                icm_pkg::CMD_ACK: begin
                  scl_oe <= 1'b1; // [R1]
                  sda_oe <= ~ackv_r; // [R1]
                  state_r <= icm_pkg::S_AK_LOW;
                end
                icm_pkg::CMD_TX: begin
                  sh_r <= txd_r;
                  bit_r <= icm_pkg::FIRST_BIT_IDX; // [R16]
                  scl_oe <= 1'b1;
                  sda_oe <= ~txd_r[DATA_W-1];
                  state_r <= icm_pkg::S_TX_LOW;
                end
                default: state_r <= icm_pkg::S_FIN;
              endcase
            end
          end
          // Start: both lines must be free first
          icm_pkg::S_ST_CHK: begin
            if (!sda_s2 || !scl_s2) begin
              bcl_l_r <= 1'b1; // [R17]
              state_r <= icm_pkg::S_FIN;
            end else begin
              cnt_r <= baud_r; // [R18]
              state_r <= icm_pkg::S_ST_HOLD;
            end
          end
          icm_pkg::S_ST_HOLD: begin
            if (!scl_s2) begin
              bcl_l_r <= 1'b1; // [R18]
              state_r <= icm_pkg::S_FIN;
            end else if (!sda_s2 || cnt_zero(cnt_r)) begin
              // Another master got there first: pull early
              sda_oe <= 1'b1; // [R19]
              cnt_r <= baud_r; // [R19]
              state_r <= icm_pkg::S_ST_SDAL;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_ST_SDAL: begin
            // SCL low here is not a collision
            if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b1; // [R19]
              state_r <= icm_pkg::S_FIN;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          // Restart: SDA released while SCL held low
          icm_pkg::S_RS_REL: begin
            if (scl_s2) begin
              cnt_r <= baud_r; // Wait for our own low first
            end else if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b0; // [R20]
              state_r <= icm_pkg::S_RS_SCLH;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_RS_SCLH: begin
            if (scl_s2) begin
              if (!sda_s2) begin
                bcl_l_r <= 1'b1; // [R20]
                state_r <= icm_pkg::S_FIN;
              end else begin
                cnt_r <= baud_r; // [R21]
                state_r <= icm_pkg::S_RS_HOLD;
              end
            end
          end
          icm_pkg::S_RS_HOLD: begin
            if (!scl_s2) begin
              bcl_l_r <= 1'b1; // [R21]
              state_r <= icm_pkg::S_FIN;
            end else if (!sda_s2 || cnt_zero(cnt_r)) begin
              sda_oe <= 1'b1; // [R22] [R21]
              cnt_r <= baud_r; // [R22]
              state_r <= icm_pkg::S_RS_SDAL;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_RS_SDAL: begin
            if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b1; // [R22]
              state_r <= icm_pkg::S_FIN;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          // Stop: SDA low, then SCL up, then SDA up
          icm_pkg::S_SP_SDAL: begin
            if (!sda_s2) begin
              cnt_r <= baud_r; // [R5]
              state_r <= icm_pkg::S_SP_CNT;
            end
          end
          icm_pkg::S_SP_CNT: begin
            if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b0; // [R5]
              cnt_r <= baud_r;
              state_r <= icm_pkg::S_SP_SCLH;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_SP_SCLH: begin
            // Counting restarts from the reload while a slave stretches the clock
            if (!scl_s2) begin
              cnt_r <= baud_r;
            end else if (cnt_zero(cnt_r)) begin
              sda_oe <= 1'b0; // [R5]
              state_r <= icm_pkg::S_SP_SDAH;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_SP_SDAH: begin
            if (!scl_s2) begin
              bcl_l_r <= 1'b1; // [R14]
              state_r <= icm_pkg::S_FIN;
            end else if (sda_s2) begin
              cnt_r <= baud_r; // [R6]
              state_r <= icm_pkg::S_SP_END;
            end
          end
          icm_pkg::S_SP_END: begin
            if (cnt_zero(cnt_r)) begin
              state_r <= icm_pkg::S_FIN; // [R6]
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          // Acknowledge clock driven by this master
          icm_pkg::S_AK_LOW: begin
            if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b0; // [R3]
              state_r <= icm_pkg::S_AK_WAITH;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_AK_WAITH: begin
            if (scl_s2) begin
              cnt_r <= baud_r; // [R3]
              state_r <= icm_pkg::S_AK_HIGH;
            end
          end
          icm_pkg::S_AK_HIGH: begin
            if (!sda_oe && !sda_s2) begin
              bcl_l_r <= 1'b1; // [R12] [R14]
              state_r <= icm_pkg::S_FIN;
            end else if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b1; // [R3]
              state_r <= icm_pkg::S_FIN;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          // Byte send, then a ninth clock with SDA released
          icm_pkg::S_TX_LOW: begin
            if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b0;
              state_r <= icm_pkg::S_TX_WAITH;
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          icm_pkg::S_TX_WAITH: begin
            if (scl_s2) begin
              cnt_r <= baud_r;
              state_r <= icm_pkg::S_TX_HIGH;
            end
          end
          icm_pkg::S_TX_HIGH: begin
            if (bit_r != icm_pkg::ACK_BIT_IDX && !sda_oe && !sda_s2) begin
              bcl_l_r <= 1'b1; // [R12] [R13]
              state_r <= icm_pkg::S_FIN;
            end else if (cnt_zero(cnt_r)) begin
              scl_oe <= 1'b1;
              cnt_r <= baud_r;
              if (bit_r == icm_pkg::ACK_BIT_IDX) begin
                state_r <= icm_pkg::S_FIN;
              end else begin
                bit_r <= bit_r + 4'h1;
                sh_r <= {sh_r[DATA_W-2:0], 1'b1};
                // After the eighth bit SDA is left to the slave
                sda_oe <= (bit_r == icm_pkg::ACK_BIT_IDX - 4'h1)
                  ? 1'b0 : ~sh_r[DATA_W-2];
                state_r <= icm_pkg::S_TX_LOW;
              end
            end else begin
              cnt_r <= cnt_r - 1'b1;
            end
          end
          // Report the end; a collision lets go of both lines
          icm_pkg::S_FIN: begin
            if (bcl_l_r) begin
              sda_oe <= 1'b0; // [R13] [R14] [R12]
              scl_oe <= 1'b0; // [R13] [R14]
            end
            done_tgl_r <= ~done_tgl_r;
            state_r <= icm_pkg::S_IDLE;
          end
          default: state_r <= icm_pkg::S_IDLE;
        endcase
      end
    end
  end

endmodule : icm_master
`default_nettype wire

// ==== icm_pkg.sv ====
// Shared constants and types for the two-wire master condition sequencer
`default_nettype none
package icm_pkg;
  // Width of the baud reload value and of the data byte
  localparam int RELOAD_W = 7;
  localparam int DATA_W = 8;
  // Bit index at which the ninth, acknowledge clock is reached
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [3:0] FIRST_BIT_IDX = 4'h0;
  // Reset value of the baud counter
  localparam logic [RELOAD_W-1:0] CNT_RESET = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  // Level driven on a line while its enable is high (open drain)
  localparam logic LINE_PULL = 1'b0;

  // Sequence requested by software
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_START = 3'b001,
    CMD_RESTART = 3'b010,
    CMD_STOP = 3'b011,
    CMD_ACK = 3'b100,
    CMD_TX = 3'b101
  } icm_cmd_type;

  // Link-side sequencer states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00000,
    S_ST_CHK = 5'b00001,
    S_ST_HOLD = 5'b00010,
    S_ST_SDAL = 5'b00011,
    S_RS_REL = 5'b00100,
    S_RS_SCLH = 5'b00101,
    S_RS_HOLD = 5'b00110,
    S_RS_SDAL = 5'b00111,
    S_SP_SDAL = 5'b01000,
    S_SP_CNT = 5'b01001,
    S_SP_SCLH = 5'b01010,
    S_SP_SDAH = 5'b01011,
    S_SP_END = 5'b01100,
    S_AK_LOW = 5'b01101,
    S_AK_WAITH = 5'b01110,
    S_AK_HIGH = 5'b01111,
    S_TX_LOW = 5'b10000,
    S_TX_WAITH = 5'b10001,
    S_TX_HIGH = 5'b10010,
    S_FIN = 5'b10011
  } icm_state_type;
endpackage : icm_pkg
`default_nettype wire

// ==== icm_master_monitor.sv ====
// Checker for the two-wire master condition sequencer
`default_nettype none
module icm_master_monitor (
  // Clock, reset and controls
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic port_enable,
  input wire logic buf_wr,
  input wire logic irq_enable,
  input wire logic sleep_mode,
  // Requests and flags
  input wire logic start_request,
  input wire logic restart_request,
  input wire logic stop_request,
  input wire logic ack_sequence_request,
  input wire logic buffer_full_flag,
  input wire logic write_collision_flag,
  input wire logic serial_event_flag,
  input wire logic bus_collision_flag,
  input wire logic start_detected,
  input wire logic stop_detected,
  input wire logic bus_free,
  input wire logic wake,
  // Pin levels
  input wire logic sda_o,
  input wire logic scl_o
);
  // All checks live in the processor domain
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  pins_low_a: assert property (!sda_o && !scl_o)
    else $error("pin drive level not low");
  write_collision_flag_ack_a: assert property (ce && port_enable && buf_wr &&
    ack_sequence_request |=> write_collision_flag)
    else $error("ack write collision lost");
  write_collision_flag_stop_a: assert property (ce && port_enable && stop_request &&
    buf_wr |=> write_collision_flag) else $error("stop write collision lost");
  detect_clr_a: assert property (ce && !port_enable |=>
    !start_detected && !stop_detected) else $error("detect bits kept");
  abort_a: assert property (ce && !port_enable |=> !start_request &&
    !restart_request && !stop_request && !ack_sequence_request)
    else $error("request kept while disabled");
  bus_free_a: assert property (bus_free |-> stop_detected ||
    !start_detected) else $error("bus free while busy");
  collide_rel_a: assert property ($rose(bus_collision_flag) |->
    ##[0:4] !(start_request || restart_request || stop_request ||
    ack_sequence_request || buffer_full_flag))
    else $error("collision left work pending");
  wake_level_a: assert property ($past(ce) |-> wake ==
    $past(sleep_mode && irq_enable && serial_event_flag))
    else $error("wake level wrong");
endmodule : icm_master_monitor
`default_nettype wire

// ==== icm_bus_model.sv ====
// Open-drain bus with pull-ups and another party able to hold lines low
`default_nettype none
module icm_bus_model (
  // Device enables and other party holds
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic hold_sda,
  input wire logic hold_scl,
  // Resolved line levels
  output logic sda_i,
  output logic scl_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up wins unless somebody pulls low; a hold on SCL stretches the clock
  assign sda_i = !(sda_oe || hold_sda);
  assign scl_i = !(scl_oe || hold_scl);
endmodule : icm_bus_model
`default_nettype wire

// ==== icm_master_tb.sv ====
// Self-checking bench for the two-wire master condition sequencer
`default_nettype none
module icm_master_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus
  logic ref_clk = 0, link_clk = 0, resetn = 0, ce = 1, port_enable = 1;
  logic irq_enable = 1, sleep_mode = 1, ack_value = 0, buf_wr = 0;
  logic hold_sda = 0, hold_scl = 0;
  logic [6:0] baud = 7'h03;
  logic [3:0] req_wr = 4'h0;
  logic [2:0] clr = 3'h0;
  logic [7:0] wdata = 8'h00;
  // Design outputs
  logic start_request, restart_request, stop_request, ack_sequence_request;
  logic buffer_full_flag, write_collision_flag, serial_event_flag;
  logic bus_collision_flag, start_detected, stop_detected, bus_free, wake;
  logic sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe;
  // Packed status and the queue of expected {mask, value}
  logic [13:0] st;
  logic [27:0] q[$];
  event chk;
  int n_fail = 0, compares = 0;
  assign st = {wake, bus_free, start_request, restart_request, stop_request,
    ack_sequence_request, buffer_full_flag, write_collision_flag,
    serial_event_flag, bus_collision_flag, start_detected, stop_detected,
    sda_oe, scl_oe};
  always #5 ref_clk = !ref_clk;
  always #24 link_clk = !link_clk;
  icm_master i_icm_master (.ref_clk, .resetn, .ce, .link_clk, .port_enable,
    .irq_enable, .sleep_mode, .ack_value, .baud_reload_value(baud),
    .start_req_wr(req_wr[0]), .restart_req_wr(req_wr[1]),
    .stop_req_wr(req_wr[2]), .ack_req_wr(req_wr[3]), .buf_wr,
    .buf_wdata(wdata), .write_collision_flag_clr(clr[0]), .event_clr(clr[1]),
    .bcol_clr(clr[2]), .start_request, .restart_request, .stop_request,
    .ack_sequence_request, .buffer_full_flag, .write_collision_flag,
    .serial_event_flag, .bus_collision_flag, .start_detected,
    .stop_detected, .bus_free, .wake, .sda_i, .sda_o, .sda_oe, .scl_i,
    .scl_o, .scl_oe);
  icm_bus_model i_icm_bus_model (.sda_oe, .scl_oe, .hold_sda, .hold_scl,
    .sda_i, .scl_i);
  // Inputs always move one ns after the edge
  task tk;
    @(posedge ref_clk);
    #1;
  endtask : tk
  task chk_st(input logic [13:0] m, v);
    q.push_back({m, v});
    ->chk;
  endtask : chk_st
  // Bounded wait for one status bit to reach a level
  task wt(input int b, input logic l);
    for (int i = 0; i < 5000 && st[b] !== l; i++) tk;
  endtask : wt
  task pulse_clr(input logic [2:0] c);
    clr = c;
    tk;
    clr = 3'h0;
  endtask : pulse_clr
  // Issue request k, optionally write the buffer in mid-run, then check
  task run(input int k, input logic mid, input logic [13:0] m, v);
    req_wr[k] = 1'b1;
    tk;
    req_wr[k] = 1'b0;
    repeat (5) tk;
    buf_wr = mid;
    tk;
    buf_wr = 1'b0;
    wt(11 - k, 1'b0);
    repeat (8) tk;
    chk_st(m, v);
    $display("test with request %0d done", k);
  endtask : run
  // Watcher: oldest expectation against the settled status
  always @(chk) begin
    logic [27:0] e;
    e = q.pop_front();
    compares++;
    if ((st & e[27:14]) !== e[13:0]) begin
      n_fail++;
      $display("Error status expected %h seen %h", e[13:0], st & e[27:14]);
    end
  end
  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Hang guard, far beyond the few tens of microseconds needed
  initial begin
    #400us;
    n_fail++;
    conclude;
  end
  initial begin
    void'($urandom(32'h1c6425e2));
    repeat (20) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (8) tk;
    baud = 7'($urandom_range(5, 2));
    run(0, 1'b0, 14'h3f3b, 14'h202b);
    pulse_clr(3'h2);
    run(1, 1'b0, 12'hf33, 12'h023);
    pulse_clr(3'h2);
    wdata = 8'($urandom);
    buf_wr = 1'b1;
    tk;
    buf_wr = 1'b0;
    wt(5, 1'b1);
    $display("byte send test done");
    tk;
    ack_value = 1'($urandom);
    hold_scl = 1'b1;
    // Slow partner: SCL stays low while the ack bit is shown
    fork
      begin
        repeat (200) tk;
        chk_st(12'h103, {10'h040, !ack_value, 1'b0});
        hold_scl = 1'b0;
      end
    join_none
    run(3, 1'b1, 12'hf41, 12'h041);
    pulse_clr(3'h3);
    run(2, 1'b1, 12'hf67, 12'h064);
    pulse_clr(3'h3);
    hold_sda = 1'b1;
    run(0, 1'b0, 12'hf13, 12'h010);
    hold_sda = 1'b0;
    repeat (40) tk;
    pulse_clr(3'h6);
    run(0, 1'b0, 12'hf13, 12'h003);
    hold_sda = 1'b1;
    pulse_clr(3'h2);
    wdata = 8'h80 | 8'($urandom);
    buf_wr = 1'b1;
    tk;
    buf_wr = 1'b0;
    wt(4, 1'b1);
    repeat (8) tk;
    chk_st(12'h093, 12'h010);
    $display("send collision test done");
    hold_sda = 1'b0;
    repeat (80) tk;
    chk_st(14'h3020, 14'h3020);
    pulse_clr(3'h7);
    req_wr[0] = 1'b1;
    tk;
    req_wr[0] = 1'b0;
    repeat (10) tk;
    port_enable = 1'b0;
    repeat (4) tk;
    chk_st(14'h3f8c, 14'h0000);
    $display("disable test done");
    conclude;
  end
endmodule : icm_master_tb
bind icm_master icm_master_monitor i_icm_master_monitor (.*);
`default_nettype wire
